// ==== hw/gate_ctrl.sv ====
`timescale 1ns/1ps
// Function
// - Phase inputs are edge sensitive; a leading edge drops the complement at once.
// - The selected switch turns on only after the programmed deadtime.
// - Every turn-off starts a timer that blocks the complementary turn-on.
// - A turn-on after the deadtime has elapsed acts with no added delay.
// - Deadtime set in 50 ns steps, from zero up to 12 us.
// - Host calibrates the step length through a register before relying on it.
// - Simultaneous-on mode lets both switches conduct and disables blanking.
// - The simultaneous-on command is accepted once per reset only.
// - Operating modes (desaturation handling, zero deadtime) can be set and locked.
// - Registers select reported faults and enable interrupt sources.
// - Status registers are readable by the host.
// - High side refused after enable until its low side has conducted once.
// - Current-limit detection blanked right after every input change.
// - Phase inputs are active low and idle high when undriven.
module gate_ctrl
  import gate_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] phase_high_side_command_n,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] phase_low_side_command_n,
  input wire logic fault_overcurrent,
  input wire logic fault_desat,
  input wire logic fault_phase_err,
  output logic [gate_ctrl_pkg::PHASES-1:0] hs_gate,
  output logic [gate_ctrl_pkg::PHASES-1:0] ls_gate,
  output logic [gate_ctrl_pkg::PHASES-1:0] current_limit_blank,
  output logic irq
);
  // ==========================================================
  // Declarations
  logic enable_q;
  logic [STEP_W-1:0] dt_steps_q;
  logic [CAL_W-1:0] cal_q;
  logic desat_keep_q;
  logic zero_dt_q;
  logic mode_lock_q;
  logic simul_q;
  logic simul_used_q;
  logic [EVT_W-1:0] report_q;
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] int_en_q;
  logic [31:0] prdata_q;
  logic [DT_W-1:0] dt_cycles_q;
  logic setup;
  logic wr_access;
  logic addr_ok;
  logic kill;
  logic [EVT_W-1:0] events;
  logic [PHASES-1:0] hs_level;
  logic [PHASES-1:0] hs_lead;
  logic [PHASES-1:0] hs_trail;
  logic [PHASES-1:0] ls_level;
  logic [PHASES-1:0] ls_lead;
  logic [PHASES-1:0] ls_trail;
  logic [2:0] flt_level;
  logic [PHASES-1:0] boot_done;
  logic [PHASES-1:0] dt_busy;
  logic [PHASES-1:0] hs_refused;

  // ==========================================================
  // Register decode helpers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_CTRL) || (a == ADDR_DEADTIME) || (a == ADDR_CAL) ||
                (a == ADDR_MODE) || (a == ADDR_SIMUL) || (a == ADDR_REPORT) ||
                (a == ADDR_STATUS) || (a == ADDR_CLEAR) || (a == ADDR_INT_EN) ||
                (a == ADDR_STATE);
  endfunction

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target, input logic w);
    wr_hit = w && (a == target);
  endfunction

  // ==========================================================
  // Pin inputs: two flip-flops before any logic; active low, idle high
  pin_sync #(
    .WIDTH(PHASES)
  ) u_hs_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(phase_high_side_command_n),
    .level(hs_level),
    .fall(hs_lead),
    .rise(hs_trail)
  );

  pin_sync #(
    .WIDTH(PHASES)
  ) u_ls_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(phase_low_side_command_n),
    .level(ls_level),
    .fall(ls_lead),
    .rise(ls_trail)
  );

  // Fault detector levels come from the analog side, unsynchronised
  pin_sync #(
    .WIDTH(3)
  ) u_flt_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(~{fault_phase_err, fault_desat, fault_overcurrent}),
    .level(flt_level),
    .fall(),
    .rise()
  );

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && addr_ok;
  assign addr_ok = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_q;

  // Read data captured in setup so the access phase answers from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (setup && !pwrite)
    begin
      prdata_q <= '0;
      unique case (paddr)
        ADDR_CTRL: prdata_q[CTRL_ENABLE_BIT] <= enable_q;
        ADDR_DEADTIME: prdata_q[STEP_W-1:0] <= dt_steps_q;
        ADDR_CAL: prdata_q[CAL_W-1:0] <= cal_q;
        ADDR_MODE:
        begin
          prdata_q[MODE_DESAT_KEEP_BIT] <= desat_keep_q;
          prdata_q[MODE_ZERO_DT_BIT] <= zero_dt_q;
          prdata_q[MODE_LOCK_BIT] <= mode_lock_q;
        end
        ADDR_SIMUL: prdata_q[1:0] <= {simul_used_q, simul_q};
        ADDR_REPORT: prdata_q[EVT_W-1:0] <= report_q;
        ADDR_STATUS: prdata_q[EVT_W-1:0] <= status_q;
        ADDR_INT_EN: prdata_q[EVT_W-1:0] <= int_en_q;
        ADDR_STATE: prdata_q[23:0] <= {ls_level, hs_level, dt_busy, boot_done,
                                       ls_gate, hs_gate, 6'h00};
        default: prdata_q <= '0;
      endcase
    end
  end

  // ==========================================================
  // Enable and deadtime programming
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q <= 1'b0;
      dt_steps_q <= DEADTIME_RESET;
      cal_q <= CAL_RESET;
    end
    else
    begin
      if (wr_hit(paddr, ADDR_CTRL, wr_access))
        enable_q <= pwdata[CTRL_ENABLE_BIT];
      // Step count saturates at the 12 us ceiling
      if (wr_hit(paddr, ADDR_DEADTIME, wr_access))
        dt_steps_q <= (pwdata[STEP_W-1:0] > STEP_W'(DT_MAX_STEPS)) ?
                      STEP_W'(DT_MAX_STEPS) : pwdata[STEP_W-1:0];
      if (wr_hit(paddr, ADDR_CAL, wr_access))
        cal_q <= pwdata[CAL_W-1:0];
    end
  end

  // Deadtime in cycles, registered to keep the multiplier off the gate path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dt_cycles_q <= '0;
    else
      dt_cycles_q <= DT_W'(dt_steps_q * cal_q);
  end

  // ==========================================================
  // Lockable operating modes: writes ignored once locked, until reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      desat_keep_q <= 1'b0;
      zero_dt_q <= 1'b0;
      mode_lock_q <= 1'b0;
    end
    else if (wr_hit(paddr, ADDR_MODE, wr_access) && !mode_lock_q)
    begin
      desat_keep_q <= pwdata[MODE_DESAT_KEEP_BIT];
      zero_dt_q <= pwdata[MODE_ZERO_DT_BIT];
      mode_lock_q <= pwdata[MODE_LOCK_BIT];
    end
  end

  // Simultaneous-on: keyed, and only the first keyed write after reset counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      simul_q <= 1'b0;
      simul_used_q <= 1'b0;
    end
    else if (wr_hit(paddr, ADDR_SIMUL, wr_access) && !simul_used_q &&
             pwdata[SIMUL_KEY_LSB+15:SIMUL_KEY_LSB] == SIMUL_KEY)
    begin
      simul_q <= pwdata[SIMUL_ON_BIT];
      simul_used_q <= 1'b1;
    end
  end

  // ==========================================================
  // Fault report selection and interrupt enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      report_q <= REPORT_RESET;
      int_en_q <= INT_EN_RESET;
    end
    else
    begin
      if (wr_hit(paddr, ADDR_REPORT, wr_access))
        report_q <= pwdata[EVT_W-1:0];
      if (wr_hit(paddr, ADDR_INT_EN, wr_access))
        int_en_q <= pwdata[EVT_W-1:0];
    end
  end

  // Faults are levels; a standing fault re-sets its bit after a clear
  // Synchroniser idles high, so faults go in inverted and are inverted back
  assign events = {|hs_refused, ~flt_level} & report_q;

  // Sticky status; an event in the clear cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= '0;
    else if (wr_hit(paddr, ADDR_CLEAR, wr_access))
      status_q <= (status_q & ~pwdata[EVT_W-1:0]) | events;
    else
      status_q <= status_q | events;
  end

  // Level interrupt while any enabled status bit stands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status_q & int_en_q);
  end

  // Registered desaturation fault shuts every driver down unless kept on
  assign kill = status_q[EVT_DESAT] && !desat_keep_q;

  // ==========================================================
  // Phase channels
  for (genvar p = 0; p < PHASES; p++)
  begin : g_phase
    phase_channel u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .hs_lead(hs_lead[p]),
      .hs_trail(hs_trail[p]),
      .ls_lead(ls_lead[p]),
      .ls_trail(ls_trail[p]),
      .enable(enable_q),
      .kill(kill),
      .simul(simul_q),
      .zero_dt(zero_dt_q),
      .dt_cycles(dt_cycles_q),
      .hs_gate(hs_gate[p]),
      .ls_gate(ls_gate[p]),
      .boot_done(boot_done[p]),
      .dt_busy(dt_busy[p]),
      .blank(current_limit_blank[p]),
      .hs_refused(hs_refused[p])
    );
  end
endmodule

// ==== hw/gate_ctrl_pkg.sv ====
// ==========================================================
// Shared constants of the three-phase gate control block
package gate_ctrl_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int DT_STEP_NS = 50;
  localparam int DT_MAX_NS = 12000;
  localparam int DT_MAX_STEPS = DT_MAX_NS / DT_STEP_NS;
  // Least time, so round up to whole cycles
  localparam int DT_STEP_CYCLES = (DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_NS = 500;
  localparam int BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Widths
  localparam int PHASES = 3;
  localparam int STEP_W = 8;
  localparam int CAL_W = 8;
  localparam int DT_W = STEP_W + CAL_W;
  localparam int BLANK_W = 8;
  localparam int EVT_W = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEADTIME = 8'h04;
  localparam logic [7:0] ADDR_CAL = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0c;
  localparam logic [7:0] ADDR_SIMUL = 8'h10;
  localparam logic [7:0] ADDR_REPORT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_CLEAR = 8'h1c;
  localparam logic [7:0] ADDR_INT_EN = 8'h20;
  localparam logic [7:0] ADDR_STATE = 8'h24;

  // ==========================================================
  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int MODE_DESAT_KEEP_BIT = 0;
  localparam int MODE_ZERO_DT_BIT = 1;
  localparam int MODE_LOCK_BIT = 31;
  localparam int SIMUL_ON_BIT = 0;
  localparam int SIMUL_KEY_LSB = 16;
  localparam logic [15:0] SIMUL_KEY = 16'h5a3c;
  localparam int EVT_OVERCURRENT = 0;
  localparam int EVT_DESAT = 1;
  localparam int EVT_PHASE_ERR = 2;
  localparam int EVT_HS_REFUSED = 3;

  // ==========================================================
  // Reset values
  localparam logic [STEP_W-1:0] DEADTIME_RESET = 8'h00;
  localparam logic [CAL_W-1:0] CAL_RESET = CAL_W'(DT_STEP_CYCLES);
  localparam logic [EVT_W-1:0] REPORT_RESET = 4'hf;
  localparam logic [EVT_W-1:0] INT_EN_RESET = 4'h0;

endpackage

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser with edge pulses taken behind stage two
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;

  // Pins idle high (pulled up), so reset to the idle level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '1;
      sync_q <= '1;
      last_q <= '1;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edges only look at the second stage onward
  assign level = sync_q;
  assign fall = last_q & ~sync_q;
  assign rise = ~last_q & sync_q;
endmodule

// ==== hw/phase_channel.sv ====
`timescale 1ns/1ps
// ==========================================================
// One phase: edge-driven selection, two deadtime timers, bootstrap hold
module phase_channel
  import gate_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hs_lead,
  input wire logic hs_trail,
  input wire logic ls_lead,
  input wire logic ls_trail,
  input wire logic enable,
  input wire logic kill,
  input wire logic simul,
  input wire logic zero_dt,
  input wire logic [gate_ctrl_pkg::DT_W-1:0] dt_cycles,
  output logic hs_gate,
  output logic ls_gate,
  output logic boot_done,
  output logic dt_busy,
  output logic blank,
  output logic hs_refused
);
  logic want_hs_q;
  logic want_ls_q;
  logic hs_gate_q;
  logic ls_gate_q;
  logic boot_q;
  logic [DT_W-1:0] hs_off_tmr_q;
  logic [DT_W-1:0] ls_off_tmr_q;
  logic [BLANK_W-1:0] blank_q;
  logic no_delay;
  logic hs_gate_d;
  logic ls_gate_d;

  assign no_delay = simul | zero_dt;

  // Leading edge selects one side and, outside simul mode, drops the other at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      want_hs_q <= 1'b0;
      want_ls_q <= 1'b0;
    end
    else
    begin
      if (hs_lead)
        want_hs_q <= 1'b1;
      else if (hs_trail || (ls_lead && !simul))
        want_hs_q <= 1'b0;
      if (ls_lead)
        want_ls_q <= 1'b1;
      else if (ls_trail || (hs_lead && !simul))
        want_ls_q <= 1'b0;
    end
  end

  // Turn-on waits only for the timer of the complementary switch
  always_comb
  begin
    hs_gate_d = enable && !kill && want_hs_q && !hs_lead_block() && boot_q;
    ls_gate_d = enable && !kill && want_ls_q && (ls_off_block() == 1'b0);
    // Lead drops the complement at once, zero deadtime or not
    if (!simul)
    begin
      hs_gate_d = hs_gate_d && !ls_lead;
      ls_gate_d = ls_gate_d && !hs_lead;
    end
    if (!no_delay)
    begin
      // Complement must be fully off before this side turns on
      hs_gate_d = hs_gate_d && !ls_gate_q;
      ls_gate_d = ls_gate_d && !hs_gate_q;
    end
  end

  function automatic logic hs_lead_block();
    hs_lead_block = !no_delay && (ls_off_tmr_q != '0);
  endfunction

  function automatic logic ls_off_block();
    ls_off_block = !no_delay && (hs_off_tmr_q != '0);
  endfunction

  // Gate outputs registered; an elapsed timer adds no delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_gate_q <= 1'b0;
      ls_gate_q <= 1'b0;
    end
    else
    begin
      hs_gate_q <= hs_gate_d;
      ls_gate_q <= ls_gate_d;
    end
  end

  // Timer starts whenever a switch goes from on to off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_off_tmr_q <= '0;
      ls_off_tmr_q <= '0;
    end
    else
    begin
      if (hs_gate_q && !hs_gate_d)
        hs_off_tmr_q <= dt_cycles;
      else if (hs_off_tmr_q != '0)
        hs_off_tmr_q <= hs_off_tmr_q - 1'b1;
      if (ls_gate_q && !ls_gate_d)
        ls_off_tmr_q <= dt_cycles;
      else if (ls_off_tmr_q != '0)
        ls_off_tmr_q <= ls_off_tmr_q - 1'b1;
    end
  end

  // Bootstrap record: low side must conduct once per enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot_q <= 1'b0;
    else if (!enable)
      boot_q <= 1'b0;
    else if (ls_gate_q)
      boot_q <= 1'b1;
  end

  // Current-limit blanking after every input change, off in simul mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blank_q <= '0;
    else if (simul)
      blank_q <= '0;
    else if (hs_lead || hs_trail || ls_lead || ls_trail)
      blank_q <= BLANK_W'(BLANK_CYCLES);
    else if (blank_q != '0)
      blank_q <= blank_q - 1'b1;
  end

  assign hs_gate = hs_gate_q;
  assign ls_gate = ls_gate_q;
  assign boot_done = boot_q;
  assign dt_busy = (hs_off_tmr_q != '0) || (ls_off_tmr_q != '0);
  assign blank = blank_q != '0;
  assign hs_refused = hs_lead && enable && !boot_q;
endmodule

// ==== bench/gate_ctrl_monitor.sv ====
`timescale 1ns/1ps
// ==========================================================
// Port checker for the gate control block
module gate_ctrl_monitor
  import gate_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] phase_high_side_command_n,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] phase_low_side_command_n,
  input wire logic fault_overcurrent,
  input wire logic fault_desat,
  input wire logic fault_phase_err,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] hs_gate,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] ls_gate,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] current_limit_blank,
  input wire logic irq
);
  logic ien_q;
  logic sim_q;
  logic [PHASES-1:0] seen_q;
  logic wr;

  assign wr = psel && penable && pwrite;

  // Sticky helper flags; conservative, so only cleared by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ien_q <= 1'b0;
      sim_q <= 1'b0;
      seen_q <= '0;
    end
    else
    begin
      if (wr && paddr == ADDR_INT_EN)
        ien_q <= 1'b1;
      if (wr && paddr == ADDR_SIMUL && pwdata[31:16] == SIMUL_KEY)
        sim_q <= 1'b1;
      seen_q <= seen_q | ls_gate;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Assertions
  gate_overlap_a: assert property (!sim_q |-> (hs_gate & ls_gate) == '0)
    else $error("high and low gate on together");
  hs_lead_a: assert property ($fell(phase_high_side_command_n[0]) |-> ##[1:6] !ls_gate[0])
    else $error("low gate kept after high lead");
  ls_lead_a: assert property ($fell(phase_low_side_command_n[0]) |-> ##[1:6] !hs_gate[0])
    else $error("high gate kept after low lead");
  hs_trail_a: assert property ($rose(phase_high_side_command_n[0]) |-> ##[1:6] !hs_gate[0])
    else $error("high gate kept with pin idle");
  hs_turnon_a: assert property ($rose(hs_gate[0]) |-> !ls_gate[0] && !$past(ls_gate[0]))
    else $error("high gate rose without gap");
  boot_hold_a: assert property ($rose(hs_gate[0]) |-> seen_q[0])
    else $error("high gate before any low conduction");
  blank_start_a: assert property (!sim_q && ($fell(phase_high_side_command_n[0])
    || $fell(phase_low_side_command_n[0])) |-> ##[1:6] current_limit_blank[0] [*8])
    else $error("blanking missing after input change");
  irq_mask_a: assert property (!ien_q |-> !irq)
    else $error("interrupt with sources disabled");
  reset_off_a: assert property ($rose(presetn) |-> hs_gate == '0 && ls_gate == '0)
    else $error("gate on right after reset");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule

bind gate_ctrl gate_ctrl_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .phase_high_side_command_n, .phase_low_side_command_n, .fault_overcurrent, .fault_desat,
  .fault_phase_err, .hs_gate, .ls_gate, .current_limit_blank, .irq);

// ==== bench/phase_host.sv ====
`timescale 1ns/1ps
// ==========================================================
// Host side of the phase pins: active low, idle high
module phase_host
  import gate_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] hs_on,
  input wire logic [gate_ctrl_pkg::PHASES-1:0] ls_on,
  output logic [gate_ctrl_pkg::PHASES-1:0] hs_cmd_n,
  output logic [gate_ctrl_pkg::PHASES-1:0] ls_cmd_n
);
  // Released pins sit high, as the pull-up leaves them
  initial
  begin
    hs_cmd_n = '1;
    ls_cmd_n = '1;
  end

  // Orders change just after the edge and hold until the next one
  always @(posedge pclk)
  begin
    hs_cmd_n <= ~hs_on;
    ls_cmd_n <= ~ls_on;
  end
endmodule

// ==== bench/three_phase_deadtime_gate_control_test.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
// ==========================================================
// Self-checking bench of the gate control block
module three_phase_deadtime_gate_control_test;
  import gate_ctrl_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_type;
  localparam int DT = 5 * 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, se;
  logic fault_overcurrent, fault_desat, fault_phase_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [PHASES-1:0] hs_on, ls_on, hs_n, ls_n, hs_gate, ls_gate, current_limit_blank;
  int err_total, compares, n, i;
  row_type rows [10] = '{'{ADDR_CTRL, 32'h0, 1'b0}, '{ADDR_DEADTIME, 32'(DEADTIME_RESET), 1'b0},
    '{ADDR_CAL, 32'(CAL_RESET), 1'b0}, '{ADDR_MODE, 32'h0, 1'b0}, '{ADDR_SIMUL, 32'h0, 1'b0},
    '{ADDR_REPORT, 32'(REPORT_RESET), 1'b0}, '{ADDR_STATUS, 32'h0, 1'b0}, '{ADDR_CLEAR, 32'h0, 1'b0},
    '{ADDR_STATE, 32'h00fc0000, 1'b0}, '{8'h28, 32'h0, 1'b1}};

  phase_host u_host (.pclk, .hs_on, .ls_on, .hs_cmd_n(hs_n), .ls_cmd_n(ls_n));
  gate_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .phase_high_side_command_n(hs_n), .phase_low_side_command_n(ls_n), .fault_overcurrent, .fault_desat,
    .fault_phase_err, .hs_gate, .ls_gate, .current_limit_blank, .irq);

  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One bus transfer; waits for ready, never assumes its latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
    begin
      err_total++;
      stop_test();
    end
  endtask

  // Edges until phase 0 high gate, low gate or irq reaches v
  task automatic wt(input int s, input logic v, output int c);
    c = 0;
    while (((s == 0) ? hs_gate[0] : (s == 1) ? ls_gate[0] : irq) !== v)
    begin
      @(posedge pclk);
      c++;
      if (c > 300)
      begin
        err_total++;
        stop_test();
      end
    end
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fault_overcurrent, fault_desat, fault_phase_err, hs_on, ls_on} = '0;
    err_total = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("read data", rows[i].d, rd)
      `CHK("slave error", rows[i].e, se)
    end
    $display("test done: register table");
    apb(1'b1, ADDR_DEADTIME, 32'hff);
    apb(1'b0, ADDR_DEADTIME, 32'h0);
    `CHK("deadtime ceiling", 32'(DT_MAX_STEPS), rd)
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_CAL, 32'h4);
    apb(1'b1, ADDR_DEADTIME, 32'h5);
    hs_on <= 3'b001;
    repeat (30) @(posedge pclk);
    `CHK("high refused", 1'b0, hs_gate[0])
    `CHK("blanking", 1'b1, current_limit_blank[0])
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("refused flag", 1'b1, rd[EVT_HS_REFUSED])
    hs_on <= 3'b000;
    ls_on <= 3'b001;
    wt(1, 1'b1, n);
    hs_on <= 3'b001;
    wt(1, 1'b0, n);
    wt(0, 1'b1, n);
    `CHK("deadtime wait", 1'b1, n >= DT && n <= DT + 4)
    hs_on <= 3'b000;
    ls_on <= 3'b000;
    wt(0, 1'b0, n);
    repeat (40) @(posedge pclk);
    ls_on <= 3'b001;
    wt(1, 1'b1, n);
    `CHK("prompt turn-on", 1'b1, n < DT)
    fault_desat <= 1'b1;
    wt(1, 1'b0, n);
    fault_desat <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("desat flag", 1'b1, rd[EVT_DESAT])
    `CHK("desat shutdown", 1'b0, ls_gate[0])
    apb(1'b1, ADDR_CLEAR, 32'h2);
    wt(1, 1'b1, n);
    $display("test done: deadtime");
    apb(1'b1, ADDR_CLEAR, 32'hf);
    apb(1'b1, ADDR_INT_EN, 32'h1);
    fault_overcurrent <= 1'b1;
    wt(2, 1'b1, n);
    fault_overcurrent <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("overcurrent flag", 1'b1, rd[EVT_OVERCURRENT])
    apb(1'b1, ADDR_INT_EN, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, ADDR_CLEAR, 32'h1);
    apb(1'b1, ADDR_REPORT, 32'he);
    fault_overcurrent <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    fault_overcurrent <= 1'b0;
    `CHK("unreported fault", 4'h0, rd[3:0])
    $display("test done: interrupt");
    apb(1'b1, ADDR_MODE, 32'h80000002);
    apb(1'b1, ADDR_MODE, 32'h0);
    apb(1'b0, ADDR_MODE, 32'h0);
    `CHK("mode locked", 32'h80000002, rd)
    apb(1'b1, ADDR_SIMUL, 32'h1);
    apb(1'b0, ADDR_SIMUL, 32'h0);
    `CHK("unkeyed simul", 32'h0, rd)
    apb(1'b1, ADDR_SIMUL, {SIMUL_KEY, 16'h1});
    apb(1'b1, ADDR_SIMUL, {SIMUL_KEY, 16'h0});
    apb(1'b0, ADDR_SIMUL, 32'h0);
    `CHK("simul once", 32'h3, rd)
    ls_on <= 3'b000;
    repeat (6) @(posedge pclk);
    `CHK("no blank in simul", 1'b0, current_limit_blank[0])
    $display("test done: modes");
    presetn <= 1'b0;
    ls_on <= 3'b000;
    repeat (2) @(posedge pclk);
    `CHK("gates in reset", 6'h0, {hs_gate, ls_gate})
    presetn <= 1'b1;
    apb(1'b0, ADDR_SIMUL, 32'h0);
    `CHK("simul after reset", 32'h0, rd)
    apb(1'b0, ADDR_DEADTIME, 32'h0);
    `CHK("deadtime after reset", 32'h0, rd)
    $display("test done: second reset");
    stop_test();
  end
endmodule
